/* shared/prsc_pkg.sv */
// constants, register map and state types for the pll reference select control
package prsc_pkg;
    // register indices and byte addresses (byte address = 4 * index)
    localparam logic [11:0] PRSC_IDX_STATUS_CTRL = 12'h017;
    localparam logic [11:0] PRSC_IDX_SEL_CTRL    = 12'h01c;
    localparam logic [11:0] PRSC_IDX_OPT_CTRL    = 12'h01d;
    localparam logic [11:0] PRSC_IDX_STATE       = 12'h020;
    localparam logic [11:0] PRSC_ADDR_STATUS_CTRL = PRSC_IDX_STATUS_CTRL << 2;
    localparam logic [11:0] PRSC_ADDR_SEL_CTRL    = PRSC_IDX_SEL_CTRL << 2;
    localparam logic [11:0] PRSC_ADDR_OPT_CTRL    = PRSC_IDX_OPT_CTRL << 2;
    localparam logic [11:0] PRSC_ADDR_STATE       = PRSC_IDX_STATE << 2;

    // reference_select_control fields
    localparam int PRSC_SEL_DEGLITCH_DIS = 7;
    localparam int PRSC_SEL_SECOND       = 6;
    localparam int PRSC_SEL_USE_PIN      = 5;
    localparam int PRSC_SEL_AUTO         = 4;
    localparam int PRSC_SEL_STAY_SECOND  = 3;
    localparam int PRSC_SEL_SECOND_PWR   = 2;
    localparam int PRSC_SEL_FIRST_PWR    = 1;
    localparam int PRSC_SEL_DIFF         = 0;
    // reference_input_options fields
    localparam int PRSC_OPT_STATUS_NVM   = 7;
    localparam int PRSC_OPT_CRYSTAL      = 6;
    localparam int PRSC_OPT_DOUBLER      = 5;
    // status pin selection field position in its register
    localparam int PRSC_STS_FIELD_LSB    = 2;

    localparam logic [7:0] PRSC_SEL_CTRL_RESET    = 8'h00;
    localparam logic [7:0] PRSC_OPT_CTRL_RESET    = 8'h80;
    localparam logic [7:0] PRSC_STATUS_CTRL_RESET = 8'h00;

    // synchroniser bit positions
    localparam int PRSC_SY_PIN    = 0;
    localparam int PRSC_SY_FIRST  = 1;
    localparam int PRSC_SY_SECOND = 2;
    localparam int PRSC_SY_NVM    = 3;

    // deglitch blanking time
    localparam int PRSC_CLK_PERIOD_NS = 10;
    localparam int PRSC_DEGLITCH_NS   = 40;
    localparam logic [3:0] PRSC_DEGLITCH_CYC =
        4'((PRSC_DEGLITCH_NS + PRSC_CLK_PERIOD_NS - 1) / PRSC_CLK_PERIOD_NS);

    localparam logic [1:0] PRSC_WR_SEL  = 2'h0;
    localparam logic [1:0] PRSC_WR_OPT  = 2'h1;
    localparam logic [1:0] PRSC_WR_STS  = 2'h2;
    localparam logic [1:0] PRSC_WR_NONE = 2'h3;

    typedef enum logic [1:0] {
        PRSC_ST_RUN   = 2'b01,
        PRSC_ST_BLANK = 2'b10
    } prsc_state_t;

    typedef struct packed {
        logic [7:0]  sel_ctrl;
        logic [7:0]  opt_ctrl;
        logic [7:0]  status_ctrl;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        prsc_state_t state;
        logic [3:0]  cnt;
        logic        want_second;
        logic        active_second;
        logic        gate;
        logic        first_pwr;
        logic        second_pwr;
        logic        status_pin;
        logic        wr_pend;
        logic [1:0]  wr_idx;
        logic [31:0] hrdata;
    } prsc_regs_t;

    localparam prsc_regs_t PRSC_RESET = '{
        sel_ctrl:      PRSC_SEL_CTRL_RESET,
        opt_ctrl:      PRSC_OPT_CTRL_RESET,
        status_ctrl:   PRSC_STATUS_CTRL_RESET,
        sync1:         4'h0,
        sync2:         4'h0,
        state:         PRSC_ST_RUN,
        cnt:           4'h0,
        want_second:   1'b0,
        active_second: 1'b0,
        gate:          1'b1,
        first_pwr:     1'b0,
        second_pwr:    1'b0,
        status_pin:    1'b0,
        wr_pend:       1'b0,
        wr_idx:        PRSC_WR_NONE,
        hrdata:        32'h0000_0000
    };
endpackage

/* core/prsc_core.sv */
// pll reference select control with its ahb-lite register slave
//
// What this block does
// - in manual register mode the second reference is used when select bit 6 is 1, else the first.
// - select bit 5 chooses whether manual selection follows bit 6 or the reference choice pin.
// - bit 4 turns on automatic switchover, and software keeps single-ended mode while it is used.
// - in automatic mode bit 3 at 0 returns to the first reference once it is good, at 1 stays put.
// - bits 2 and 1 power the references, but automatic mode overrides them and powers both.
// - bit 0 picks differential mode when 1 and single-ended mode when 0.
// - option bit 7 puts the memory transfer state on the status pin, else the selection field rules.
// - option bit 6 enables the crystal maintaining amplifier.
// - option bit 5 enables the reference frequency doubler.
`timescale 1ns/1ps
`default_nettype none
module prsc_core
    import prsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ref_choice_pin,
    input  wire logic        first_ref_good,
    input  wire logic        second_ref_good,
    input  wire logic        nvm_transfer_state,
    input  wire logic        status_mux_value,
    output logic [5:0]       status_select,
    output logic             status_pin,
    output logic             second_ref_selected,
    output logic             ref_clock_gate,
    output logic             first_ref_power,
    output logic             second_ref_power,
    output logic             differential_mode,
    output logic             crystal_amplifier_enable,
    output logic             doubler_enable,
    output logic             auto_switchover_active
);
    prsc_regs_t r;
    prsc_regs_t next_r;

    // bus decode
    logic        addr_phase;
    logic        rd_take;
    logic        wr_take;
    logic [11:0] addr;
    logic [1:0]  idx;
    logic        is_state;

    // register values as seen this cycle, with a pending write folded in
    logic [7:0]  sel_now;
    logic [7:0]  opt_now;
    logic [7:0]  sts_now;
    logic [7:0]  state_byte;
    logic [7:0]  rd_byte;

    // synchronised pin levels
    logic        pin_level;
    logic        first_good;
    logic        second_good;
    logic        nvm_level;

    // selection controls and decisions
    logic        auto_mode;
    logic        use_pin;
    logic        reg_second;
    logic        stay_second;
    logic        deglitch_off;
    logic        manual_target;
    logic        auto_target;
    logic        target;
    logic        change_req;
    logic        blanking;
    logic        blank_done;

    always_comb begin
        next_r = r;

        // a transfer is taken only when the bus is ready
        addr_phase = hsel && htrans[1] && hready;
        rd_take = addr_phase && !hwrite;
        wr_take = addr_phase && hwrite;
        addr = haddr[11:0];
        idx = PRSC_WR_NONE;
        is_state = 1'b0;
        // unmapped addresses read zero and ignore writes
        case (addr)
            PRSC_ADDR_SEL_CTRL: begin
                idx = PRSC_WR_SEL;
            end
            PRSC_ADDR_OPT_CTRL: begin
                idx = PRSC_WR_OPT;
            end
            PRSC_ADDR_STATUS_CTRL: begin
                idx = PRSC_WR_STS;
            end
            PRSC_ADDR_STATE: begin
                is_state = 1'b1;
            end
            default: begin
            end
        endcase

        // data phase of a pending write commits now
        sel_now = r.sel_ctrl;
        opt_now = r.opt_ctrl;
        sts_now = r.status_ctrl;
        if (r.wr_pend) begin
            case (r.wr_idx)
                PRSC_WR_SEL: begin
                    sel_now = hwdata[7:0];
                end
                PRSC_WR_OPT: begin
                    opt_now = hwdata[7:0];
                end
                PRSC_WR_STS: begin
                    // bits below the selection field do not exist and read zero
                    sts_now = hwdata[7:0];
                    sts_now[PRSC_STS_FIELD_LSB-1:0] = '0;
                end
                default: begin
                end
            endcase
        end
        next_r.sel_ctrl = sel_now;
        next_r.opt_ctrl = opt_now;
        next_r.status_ctrl = sts_now;

        // hwdata stands only in the data phase, so the target is kept until then;
        // the state word is read-only and takes no write
        next_r.wr_pend = 1'b0;
        if (wr_take && (idx != PRSC_WR_NONE)) begin
            next_r.wr_pend = 1'b1;
        end
        next_r.wr_idx = idx;

        // state word: one bit per condition, upper bits zero
        blanking = (r.state == PRSC_ST_BLANK);
        state_byte = 8'h00;
        state_byte[0] = r.active_second;
        state_byte[1] = r.gate;
        state_byte[2] = r.first_pwr;
        state_byte[3] = r.second_pwr;
        state_byte[4] = blanking;

        // read data is captured in the address phase; a write still in its data
        // phase is forwarded so back-to-back accesses see the new value
        rd_byte = 8'h00;
        case (idx)
            PRSC_WR_SEL: begin
                rd_byte = sel_now;
            end
            PRSC_WR_OPT: begin
                rd_byte = opt_now;
            end
            PRSC_WR_STS: begin
                rd_byte = sts_now;
            end
            default: begin
                if (is_state) begin
                    rd_byte = state_byte;
                end
            end
        endcase
        // hrdata then holds until the next read
        if (rd_take) begin
            next_r.hrdata = {24'h000000, rd_byte};
        end

        // two-flop synchronisers; only the second stage is read below,
        // so a pin change reaches the logic two edges later and acts on the third edge
        next_r.sync1[PRSC_SY_PIN] = ref_choice_pin;
        next_r.sync1[PRSC_SY_FIRST] = first_ref_good;
        next_r.sync1[PRSC_SY_SECOND] = second_ref_good;
        next_r.sync1[PRSC_SY_NVM] = nvm_transfer_state;
        next_r.sync2 = r.sync1;
        pin_level = r.sync2[PRSC_SY_PIN];
        first_good = r.sync2[PRSC_SY_FIRST];
        second_good = r.sync2[PRSC_SY_SECOND];
        nvm_level = r.sync2[PRSC_SY_NVM];

        // selection controls
        auto_mode = r.sel_ctrl[PRSC_SEL_AUTO];
        use_pin = r.sel_ctrl[PRSC_SEL_USE_PIN];
        reg_second = r.sel_ctrl[PRSC_SEL_SECOND];
        stay_second = r.sel_ctrl[PRSC_SEL_STAY_SECOND];
        deglitch_off = r.sel_ctrl[PRSC_SEL_DEGLITCH_DIS];

        // manual choice: register bit or pin
        if (use_pin) begin
            manual_target = pin_level;
        end else begin
            manual_target = reg_second;
        end

        // leave the first input only when it is bad and the second is good
        if (r.active_second) begin
            if (stay_second) begin
                auto_target = 1'b1;
            end else begin
                auto_target = !first_good;
            end
        end else begin
            auto_target = !first_good && second_good;
        end

        // differential mode does not steer selection; software keeps
        // single-ended mode whenever automatic mode is on
        if (auto_mode) begin
            target = auto_target;
        end else begin
            target = manual_target;
        end
        change_req = (target != r.active_second);
        blank_done = (r.cnt == 4'h0);

        // unless select bit 7 turns deglitching off, the clock is gated off before the input changes
        // and opened on the same edge that changes it, so no shortened pulse reaches the loop
        case (r.state)
            PRSC_ST_RUN: begin
                if (change_req) begin
                    if (deglitch_off) begin
                        next_r.active_second = target;
                    end else begin
                        next_r.state = PRSC_ST_BLANK;
                        next_r.gate = 1'b0;
                        next_r.want_second = target;
                        next_r.cnt = PRSC_DEGLITCH_CYC - 4'h1;
                    end
                end
            end
            PRSC_ST_BLANK: begin
                // a change asked for while blanked waits for the next run cycle
                if (blank_done) begin
                    next_r.active_second = r.want_second;
                    next_r.gate = 1'b1;
                    next_r.state = PRSC_ST_RUN;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            default: begin
                // an illegal state recovers to run with the clock open
                next_r.state = PRSC_ST_RUN;
                next_r.gate = 1'b1;
            end
        endcase

        // automatic mode keeps both inputs powered so either can be monitored
        if (auto_mode) begin
            next_r.first_pwr = 1'b1;
            next_r.second_pwr = 1'b1;
        end else begin
            next_r.first_pwr = r.sel_ctrl[PRSC_SEL_FIRST_PWR];
            next_r.second_pwr = r.sel_ctrl[PRSC_SEL_SECOND_PWR];
        end

        // memory transfer state wins over the selection field
        if (r.opt_ctrl[PRSC_OPT_STATUS_NVM]) begin
            next_r.status_pin = nvm_level;
        end else begin
            next_r.status_pin = status_mux_value;
        end
    end

    // asynchronous reset loads constants only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= PRSC_RESET;
        end else begin
            r <= next_r;
        end
    end

    // bus response: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;

    // status pin routing
    assign status_select = r.status_ctrl[7:PRSC_STS_FIELD_LSB];
    assign status_pin = r.status_pin;

    // reference selection and power
    assign second_ref_selected = r.active_second;
    assign ref_clock_gate = r.gate;
    assign first_ref_power = r.first_pwr;
    assign second_ref_power = r.second_pwr;

    // reference input options, straight from the registers
    assign differential_mode = r.sel_ctrl[PRSC_SEL_DIFF];
    assign crystal_amplifier_enable = r.opt_ctrl[PRSC_OPT_CRYSTAL];
    assign doubler_enable = r.opt_ctrl[PRSC_OPT_DOUBLER];
    assign auto_switchover_active = r.sel_ctrl[PRSC_SEL_AUTO];
endmodule
`default_nettype wire

/* sim/prsc_props.sv */
// port assertions for the pll reference select control
`timescale 1ns/1ps
`default_nettype none
module prsc_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        second_ref_selected,
    input wire logic        ref_clock_gate,
    input wire logic        first_ref_power,
    input wire logic        second_ref_power,
    input wire logic        differential_mode,
    input wire logic        crystal_amplifier_enable,
    input wire logic        doubler_enable,
    input wire logic        auto_switchover_active
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rdata_hold_a: assert property ($past(hsel && htrans[1] && !hwrite && hready)
        || $stable(hrdata)) else $error("read data moved without a read");
    gate_blank_a: assert property ($fell(ref_clock_gate) |->
        !ref_clock_gate [*4] ##1 ref_clock_gate) else $error("blanking not 4 cycles");
    sel_blank_a: assert property (!ref_clock_gate |->
        $stable(second_ref_selected)) else $error("selection moved while blanked");
    auto_power_a: assert property (auto_switchover_active &&
        $past(auto_switchover_active) |-> first_ref_power && second_ref_power)
        else $error("auto power off");
    sel_reset_a: assert property ($rose(rstn) |-> !second_ref_selected &&
        ref_clock_gate && !first_ref_power && !second_ref_power) else $error("sel reset");
    mode_reset_a: assert property ($rose(rstn) |-> !differential_mode &&
        !crystal_amplifier_enable && !doubler_enable && !auto_switchover_active)
        else $error("mode reset");
    cover property ($fell(ref_clock_gate));
    cover property (auto_switchover_active && $rose(second_ref_selected));
    cover property ($changed(second_ref_selected) && $past(ref_clock_gate));
endmodule
bind prsc_core prsc_props u_props (.clk, .rstn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .second_ref_selected, .ref_clock_gate,
    .first_ref_power, .second_ref_power, .differential_mode,
    .crystal_amplifier_enable, .doubler_enable, .auto_switchover_active);
`default_nettype wire

/* sim/tb_pll_reference_select_control.sv */
// self-checking bench for the pll reference select control
`timescale 1ns/1ps
`default_nettype none
module tb_pll_reference_select_control;
    import prsc_pkg::*;
    logic        clk, rstn, hsel, hwrite, hreadyout, hresp;
    logic        pin, g1, g2, nvm, mux, sts, sec, gate, p1, p2, dif, xa, dbl, aut;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [5:0]  ssel;
    logic [7:0]  s, o;
    logic [2:0]  at [4] = '{3'b011, 3'b110, 3'b011, 3'b111};
    int          seed = 32'hf11c;
    int          bad_count = 0;
    int          cmp_count = 0;
    prsc_core u_dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ref_choice_pin(pin),
        .first_ref_good(g1), .second_ref_good(g2), .nvm_transfer_state(nvm),
        .status_mux_value(mux), .status_select(ssel), .status_pin(sts),
        .second_ref_selected(sec), .ref_clock_gate(gate), .first_ref_power(p1),
        .second_ref_power(p2), .differential_mode(dif), .crystal_amplifier_enable(xa),
        .doubler_enable(dbl), .auto_switchover_active(aut));
    function automatic logic exp_sec(input logic [7:0] c, input logic p);
        return c[PRSC_SEL_USE_PIN] ? p : c[PRSC_SEL_SECOND];
    endfunction
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        q = hrdata;
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rstn, hsel, hwrite, pin, g1, g2, nvm, mux, htrans, haddr, hwdata} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(PRSC_ADDR_OPT_CTRL, 1'b0, 8'h0);
        chk("opt reset", q, 32'h80);
        bus(PRSC_ADDR_STATE, 1'b1, 8'hff);
        bus(PRSC_ADDR_STATE, 1'b0, 8'h0);
        chk("state", q, 32'h2);
        bus(12'h010, 1'b1, 8'hff);
        bus(12'h010, 1'b0, 8'h0);
        chk("unmapped", q, 32'h0);
        for (int i = 0; i < 16; i++) begin
            s = 8'($random(seed));
            o = 8'($random(seed));
            s[4] = 1'b0;
            if (s[0]) s[2:1] = 2'b00;
            {pin, nvm, mux} <= 3'($random(seed));
            bus(PRSC_ADDR_SEL_CTRL, 1'b1, s);
            bus(PRSC_ADDR_OPT_CTRL, 1'b1, o);
            bus(PRSC_ADDR_STATUS_CTRL, 1'b1, o);
            bus(PRSC_ADDR_STATUS_CTRL, 1'b0, 8'h0);
            chk("sts read", q, {24'h0, o[7:2], 2'b00});
            bus(PRSC_ADDR_SEL_CTRL, 1'b0, 8'h0);
            chk("sel read", q, {24'h0, s});
            repeat (12) @(posedge clk);
            #1;
            chk("second", sec, exp_sec(s, pin));
            chk("diff", dif, s[0]);
            chk("auto", aut, s[4]);
            chk("power", {p2, p1}, s[2:1]);
            chk("crystal", xa, o[6]);
            chk("doubler", dbl, o[5]);
            chk("status", sts, o[7] ? nvm : mux);
            chk("sts field", ssel, o[7:2]);
            @(posedge clk);
        end
        foreach (at[k]) begin
            {g1, g2} <= at[k][2:1];
            bus(PRSC_ADDR_SEL_CTRL, 1'b1, k < 2 ? 8'h16 : 8'h18);
            repeat (12) @(posedge clk);
            #1;
            chk("auto sel", sec, at[k][0]);
            chk("auto pwr", {p2, p1, aut}, 3'b111);
            @(posedge clk);
        end
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(PRSC_ADDR_SEL_CTRL, 1'b0, 8'h0);
        chk("sel reset", q, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
